// file: inc/supply_monitor_defines.vh
// Functional notes
// RULE_01: Keep 12-bit IIR average, nibble in high register
// RULE_02: Filter time constant comes from control field
// RULE_03: Measure pin A when mode is 1
// RULE_04: Addressed result register holds off its updates
// RULE_05: High read copies low byte into shadow
// RULE_06: Host scales pin B code by 1.49
// RULE_07: Host scales pin A code by 1.01
// RULE_08: Track 12-bit minimum, nibble in high register
// RULE_09: Low byte register holds bits 7:0
// RULE_10: Host writes zeros to reserved bits 7:4
// RULE_11: Clear restarts average, minimum reloads full scale
`ifndef SUPPLY_MONITOR_DEFINES_VH
`define SUPPLY_MONITOR_DEFINES_VH

`define OFS_AVG_HIGH 8'h1b
`define OFS_AVG_LOW 8'h1c
`define OFS_MIN_HIGH 8'h1d
`define OFS_MIN_LOW 8'h1e
`define RESULT_RESET 8'h00
`define CODE_WIDTH 12
`define TAU_WIDTH 3
`define FRAC_BITS 8
`define FULL_SCALE 12'hfff
`define PIN_A_MODE 1'b1
`define DEVICE_ADDR 7'h2a

`endif

// file: hw/supply_tracker.v
`timescale 1ns/1ns
`default_nettype none
`include "supply_monitor_defines.vh"

module supply_tracker (
  input wire clk,
  input wire rst_n,
  input wire sample_valid,
  input wire [11:0] sample,
  input wire [2:0] tau,
  input wire clear,
  input wire hold_avg,
  input wire hold_min,
  output wire [11:0] average,
  output reg [11:0] minimum
);

  reg [19:0] acc;
  reg avg_fresh;
  reg min_fresh;
  wire signed [20:0] diff;
  wire signed [20:0] step;

  // Fixed point keeps small steps from vanishing at long time constants
  assign diff = $signed({1'b0, sample, 8'h00}) - $signed({1'b0, acc});
  assign step = diff >>> tau; // see RULE_02
  assign average = acc[19:8]; // see RULE_01

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 20'h0_0000;
      avg_fresh <= 1'b1;
    end else if (clear) begin
      acc <= 20'h0_0000; // see RULE_11
      avg_fresh <= 1'b1;
    end else if (sample_valid && !hold_avg) begin // see RULE_04
      avg_fresh <= 1'b0;
      if (avg_fresh) begin
        acc <= {sample, 8'h00};
      end else begin
        acc <= acc + step[19:0]; // see RULE_01
      end
    end
  end

  // Samples arriving during a hold are lost, not queued
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      minimum <= 12'h000;
      min_fresh <= 1'b1;
    end else if (clear) begin
      minimum <= `FULL_SCALE; // see RULE_11
      min_fresh <= 1'b1;
    end else if (sample_valid && !hold_min) begin // see RULE_04
      min_fresh <= 1'b0;
      if (min_fresh || sample < minimum) begin
        minimum <= sample; // see RULE_08
      end
    end
  end

endmodule
`default_nettype wire

// file: hw/supply_monitor_readout.v
`timescale 1ns/1ns
`default_nettype none
`include "supply_monitor_defines.vh"

module supply_monitor_readout (
  input wire clk,
  input wire rst_n,
  input wire scl,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  input wire sample_valid,
  input wire [11:0] sample_pin_a,
  input wire [11:0] sample_pin_b,
  input wire supply_present_mode,
  input wire [2:0] filter_time_constant,
  input wire clear
);

  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_ADDR = 8'h02;
  localparam [7:0] S_ACK_ADDR = 8'h04;
  localparam [7:0] S_PTR = 8'h08;
  localparam [7:0] S_ACK_WR = 8'h10;
  localparam [7:0] S_WDATA = 8'h20;
  localparam [7:0] S_TX = 8'h40;
  localparam [7:0] S_HOST_ACK = 8'h80;

  reg [2:0] scl_sync;
  reg [2:0] sda_sync;
  reg [7:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] tx_byte;
  reg [7:0] pointer;
  reg busy;
  reg is_read;
  reg host_nack;
  reg [7:0] avg_low_shadow;
  reg [7:0] min_low_shadow;
  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire [11:0] sample;
  wire [11:0] average;
  wire [11:0] minimum;
  wire hold_avg;
  wire hold_min;
  wire load_tx;
  wire [7:0] pointer_next;

  // Two stages before use; stage 0 is read only by stage 1
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 3'b111;
      sda_sync <= 3'b111;
    end else begin
      scl_sync <= {scl_sync[1:0], scl};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign scl_rise = scl_s && !scl_sync[2];
  assign scl_fall = !scl_s && scl_sync[2];
  assign start_cond = scl_s && scl_sync[2] && sda_sync[2] && !sda_s;
  assign stop_cond = scl_s && scl_sync[2] && !sda_sync[2] && sda_s;

  // Open drain: only ever pull low
  assign sda_out = 1'b0;

  assign sample = (supply_present_mode == `PIN_A_MODE) ?
                  sample_pin_a : sample_pin_b; // see RULE_03

  // Hold lasts while busy with the pointer on the pair, costing a few samples per read
  assign hold_avg = busy && (pointer == `OFS_AVG_HIGH ||
                             pointer == `OFS_AVG_LOW); // see RULE_04
  assign hold_min = busy && (pointer == `OFS_MIN_HIGH ||
                             pointer == `OFS_MIN_LOW); // see RULE_04

  supply_tracker supply_tracker_inst (
    .clk(clk),
    .rst_n(rst_n),
    .sample_valid(sample_valid),
    .sample(sample),
    .tau(filter_time_constant),
    .clear(clear),
    .hold_avg(hold_avg),
    .hold_min(hold_min),
    .average(average),
    .minimum(minimum)
  );

  function [7:0] read_mux;
    input [7:0] ofs;
    input [11:0] avg;
    input [11:0] mn;
    input [7:0] avg_sh;
    input [7:0] min_sh;
    begin
      case (ofs)
        `OFS_AVG_HIGH: read_mux = {4'h0, avg[11:8]}; // see RULE_01
        `OFS_AVG_LOW: read_mux = avg_sh; // see RULE_09
        `OFS_MIN_HIGH: read_mux = {4'h0, mn[11:8]}; // see RULE_08
        `OFS_MIN_LOW: read_mux = min_sh; // see RULE_09
        default: read_mux = `RESULT_RESET;
      endcase
    end
  endfunction

  assign load_tx = scl_fall &&
                   ((state == S_ACK_ADDR && is_read) ||
                    (state == S_HOST_ACK && !host_nack));
  assign pointer_next = pointer + 8'h01;

  // High read freezes the matching low byte for the next read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avg_low_shadow <= `RESULT_RESET;
      min_low_shadow <= `RESULT_RESET;
    end else if (load_tx) begin
      if (pointer == `OFS_AVG_HIGH) begin
        avg_low_shadow <= average[7:0]; // see RULE_05
      end
      if (pointer == `OFS_MIN_HIGH) begin
        min_low_shadow <= minimum[7:0]; // see RULE_05
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx_byte <= 8'h00;
      pointer <= 8'h00;
      busy <= 1'b0;
      is_read <= 1'b0;
      host_nack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      state <= S_ADDR;
      bit_cnt <= 4'h0;
      busy <= 1'b1;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state <= S_IDLE;
      busy <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      if (load_tx) begin
        tx_byte <= read_mux(pointer, average, minimum,
                            avg_low_shadow, min_low_shadow);
        pointer <= pointer_next;
      end
      case (state)
        S_IDLE: begin
          sda_oe <= 1'b0;
        end
        S_ADDR, S_PTR, S_WDATA: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (state == S_ADDR) begin
              if (shift[7:1] == `DEVICE_ADDR) begin
                is_read <= shift[0];
                sda_oe <= 1'b1;
                state <= S_ACK_ADDR;
              end else begin
                busy <= 1'b0;
                state <= S_IDLE;
              end
            end else begin
              // Result registers are read-only; written data is dropped
              if (state == S_PTR) begin
                pointer <= shift;
              end
              sda_oe <= 1'b1;
              state <= S_ACK_WR;
            end
          end
        end
        S_ACK_ADDR: begin
          if (scl_fall) begin
            if (is_read) begin
              sda_oe <= 1'b0;
              state <= S_TX;
            end else begin
              sda_oe <= 1'b0;
              state <= S_PTR;
            end
          end
        end
        S_ACK_WR: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state <= S_WDATA;
          end
        end
        S_TX: begin
          sda_oe <= !tx_byte[7];
          if (scl_fall) begin
            tx_byte <= {tx_byte[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h7) begin
              bit_cnt <= 4'h0;
              sda_oe <= 1'b0;
              state <= S_HOST_ACK;
            end else begin
              sda_oe <= !tx_byte[6];
            end
          end
        end
        S_HOST_ACK: begin
          sda_oe <= 1'b0;
          if (scl_rise) begin
            host_nack <= sda_s;
          end else if (scl_fall) begin
            state <= host_nack ? S_IDLE : S_TX;
          end
        end
        default: begin
          state <= S_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: bench/supply_monitor_readout_chk.sv
`timescale 1ns/1ns
`default_nettype none
module supply_monitor_readout_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  drive_zero_a: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  // Data may move only in the low phase, sync delay included
  oe_scl_low_a: assert property ($changed(sda_oe) |->
    !$past(scl) && !$past(scl, 2))
    else $error("sda_oe moved near scl high");
  oe_steady_a: assert property (scl && $past(scl) |->
    $stable(sda_oe))
    else $error("sda_oe moved with scl high");
  start_quiet_a: assert property (scl && $fell(sda_in) |->
    ##1 !sda_oe [*8])
    else $error("sda driven right after start");
  // Hold time: nothing moves in the two clocks after scl falls
  fall_hold_a: assert property ($fell(scl) |->
    $stable(sda_oe) [*2])
    else $error("sda_oe moved right after scl fall");
  stop_quiet_a: assert property (scl && $rose(sda_in) |->
    ##1 !sda_oe [*8])
    else $error("sda driven right after stop");
endmodule
bind supply_monitor_readout supply_monitor_readout_chk chk_inst (
  .clk(clk),
  .rst_n(rst_n),
  .scl(scl),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe)
);
`default_nettype wire

// file: bench/i2c_host_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "supply_monitor_defines.vh"
module i2c_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  logic [7:0] got [0:3];
  logic nak;
  // Host scaling of a paired code to millivolts, rounded down
  function automatic int to_mv(input logic [7:0] hi, input logic [7:0] lo,
    input logic pin_a);
    int code;
    code = {hi[3:0], lo};
    return code * (pin_a ? 101 : 149) / 100;
  endfunction
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Ten clocks a phase, far above the sync need
  task automatic hp;
    repeat (10) @(negedge clk);
  endtask
  task automatic start;
    hp;
    pull = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    pull = 1'b1;
    hp;
    scl = 1'b0;
  endtask
  // Nine bits; sda only moves mid low phase
  task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      hp;
      pull = !d[i];
      hp;
      scl = 1'b1;
      hp;
      q[i] = sda;
      hp;
      scl = 1'b0;
    end
  endtask
  // Only the pointer is written, never a data byte
  task automatic rd(input logic [7:0] p, input int n);
    logic [8:0] q;
    start;
    xbyte({`DEVICE_ADDR, 2'b01}, q);
    nak = q[0];
    xbyte({p, 1'b1}, q);
    nak |= q[0];
    start;
    xbyte({`DEVICE_ADDR, 2'b11}, q);
    nak |= q[0];
    for (int i = 0; i < n; i++) begin
      xbyte({8'hff, i == n - 1}, q);
      got[i] = q[8:1];
    end
    hp;
    pull = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    pull = 1'b0;
    hp;
  endtask
endmodule
`default_nettype wire

// file: bench/supply_voltage_monitor_readout_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin \
  comparisons++; \
  if ((s) !== (e)) begin \
    n_errors++; \
    $display("wrong value %s exp %h got %h", n, e, s); \
  end end
module supply_voltage_monitor_readout_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sv = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [11:0] pb = 12'h000;
  logic mode = 1'b0;
  logic [2:0] tau = 3'h0;
  logic clr = 1'b0;
  logic scl, pull, oe, so;
  wire sda = !(oe || pull);
  int n_errors = 0;
  int comparisons = 0;
  int acc = 0;
  logic [11:0] mn = 12'h000;
  logic first = 1'b1;
  logic [7:0] sh;
  always #4 clk = !clk;
  supply_monitor_readout supply_monitor_readout_inst (.clk(clk),
    .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(so), .sda_oe(oe),
    .sample_valid(sv), .sample_pin_a(pa), .sample_pin_b(pb),
    .supply_present_mode(mode), .filter_time_constant(tau), .clear(clr));
  i2c_host_model i2c_host_model_inst (.clk(clk), .sda(sda), .scl(scl),
    .pull(pull));
  // Unselected pin gets the inverse, so a wrong pick shows
  task automatic smp(input logic [11:0] v, input logic [1:0] hold);
    int x;
    x = v;
    @(negedge clk);
    pa = mode ? v : ~v;
    pb = mode ? ~v : v;
    sv = 1'b1;
    @(negedge clk);
    sv = 1'b0;
    // Bit 1 marks the average as held, bit 0 the minimum
    if (!hold[1]) begin
      acc = first ? x * 256 : acc + ((x * 256 - acc) >>> tau);
      first = 1'b0;
    end
    if (!hold[0] && v < mn) mn = v;
  endtask
  task automatic chk2(input logic [7:0] p, input logic [11:0] e);
    i2c_host_model_inst.rd(p, 2);
    `CHK("high", {4'h0, e[11:8]},
      i2c_host_model_inst.got[0])
    `CHK("low", e[7:0], i2c_host_model_inst.got[1])
    `CHK("ack", 1'b0, i2c_host_model_inst.nak)
    `CHK("millivolts", int'(e) * (mode ? 101 : 149) / 100,
      i2c_host_model_inst.to_mv(i2c_host_model_inst.got[0],
      i2c_host_model_inst.got[1], mode))
  endtask
  task automatic test_done;
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    test_done;
  end
  initial begin
    void'($urandom(32'h0000_8b05));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    i2c_host_model_inst.rd(8'h1b, 4);
    for (int i = 0; i < 4; i++)
      `CHK("reset", 8'h00, i2c_host_model_inst.got[i])
    i2c_host_model_inst.rd(8'h40, 1);
    `CHK("unmapped", 8'h00, i2c_host_model_inst.got[0])
    for (int r = 0; r < 6; r++) begin
      mode = r[0];
      tau = 3'($urandom);
      @(negedge clk);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      first = 1'b1;
      mn = 12'hfff;
      repeat (1 + r) smp(12'($urandom), 2'b00);
      chk2(8'h1b, acc[19:8]);
      chk2(8'h1d, mn);
      sh = acc[15:8];
      smp(~mn, 2'b00);
      i2c_host_model_inst.rd(8'h1c, 1);
      `CHK("shadow", sh, i2c_host_model_inst.got[0])
    end
    // Cleared minimum reads full scale before any sample
    tau = 3'h0;
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    first = 1'b1;
    mn = 12'hfff;
    chk2(8'h1d, 12'hfff);
    // Minimum held while its high byte is sent, average not
    fork
      i2c_host_model_inst.rd(8'h1d, 2);
      begin
        repeat (1200) @(negedge clk);
        smp(12'h000, 2'b01);
      end
    join
    chk2(8'h1d, mn);
    chk2(8'h1b, acc[19:8]);
    smp(12'h001, 2'b00);
    chk2(8'h1d, mn);
    // Average held while its high byte is sent; tau 0 makes a miss obvious
    fork
      i2c_host_model_inst.rd(8'h1b, 2);
      begin
        repeat (1200) @(negedge clk);
        smp(~acc[19:8], 2'b10);
      end
    join
    chk2(8'h1b, acc[19:8]);
    test_done;
  end
endmodule
`default_nettype wire
